/* File: hw/dts_cfg.svh */
`ifndef DTS_CFG_SVH
`define DTS_CFG_SVH

// ----------------------------------------
// Channel count and selector layout
// ----------------------------------------
`define DTS_NUM_CH        4
`define DTS_NUM_SRC       34
`define DTS_SEL_W         6
`define DTS_SEL_LSB       0
`define DTS_SEL_MSB       5
`define DTS_FLAG_BIT      7
`define DTS_REG_RESET     8'h00
`define DTS_SEL_NONE      6'h00
`define DTS_SEL_LVD       6'h01
`define DTS_SEL_PIN0      6'h02
`define DTS_SEL_PIN7      6'h09

`endif

/* File: hw/dts_pkg.sv */
package dts_pkg;
    `include "dts_cfg.svh"

    // Register write request for one channel
    typedef struct packed {
        logic       byte_we;   // 8-bit write of whole register
        logic       bit_we;    // 1-bit write of the request flag
        logic [7:0] wdata;     // Write data
    } dts_wr_t;

    // Per-channel start state
    typedef enum logic [0:0] {
        DTS_IDLE,
        DTS_STARTED
    } dts_state_t;
endpackage

/* File: hw/dts_trigger_select.sv */
// Notes on behaviour
// - Selected interrupt sets flag regardless of enable
// - Pending flag starts transfer once enabled
// - Standby interrupts ignored entirely
// - Selector zero disables interrupt triggers
// - Codes map LVD, pins, then peripherals
// - Flag reads one while request pending
// - Register resets zero; byte or flag-bit access
`timescale 1ns/100ps
`include "dts_cfg.svh"
module dts_trigger_select
    import dts_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                              MCLK,
    input  wire logic                              RST,
    input  wire logic                              CE,
    // Peripheral interrupt pulses, index = code - 1
    input  wire logic [`DTS_NUM_SRC-1:0]           IRQ_IN,
    input  wire logic                              STANDBY,
    // Register access per channel
    input  wire dts_wr_t [`DTS_NUM_CH-1:0]         REG_WR,
    // Channel control from software
    input  wire logic [`DTS_NUM_CH-1:0]            CHANNEL_ENABLE,
    // Register read-back and transfer start
    output logic [`DTS_NUM_CH-1:0][7:0]            TRIGGER_FACTOR_REG,
    output logic [`DTS_NUM_CH-1:0]                 TRANSFER_START
);

    // ----------------------------------------
    // Decode helper
    // ----------------------------------------
    // Picks the interrupt a selector code names; code 0 picks nothing
    function automatic logic src_hit(input logic [`DTS_SEL_W-1:0] sel,
                                     input logic [`DTS_NUM_SRC-1:0] irq);
        logic hit;
        hit = 1'b0;
        if (sel == `DTS_SEL_NONE) begin
            hit = 1'b0;
        end else if (sel <= `DTS_NUM_SRC) begin
            hit = irq[sel - 6'h01];
        end
        return hit;
    endfunction

    // ----------------------------------------
    // Channel state
    // ----------------------------------------
    logic [`DTS_NUM_CH-1:0][`DTS_SEL_W-1:0] sel_reg;      // Source selectors
    logic [`DTS_NUM_CH-1:0][`DTS_SEL_W-1:0] sel_next;
    logic [`DTS_NUM_CH-1:0]                 flag_reg;     // Request flags
    logic [`DTS_NUM_CH-1:0]                 flag_next;
    logic [`DTS_NUM_CH-1:0]                 start_reg;    // Start pulses
    logic [`DTS_NUM_CH-1:0]                 start_next;
    logic [`DTS_NUM_CH-1:0][7:0]            rd_reg;       // Read-back image
    logic [`DTS_NUM_CH-1:0][7:0]            rd_next;
    logic [`DTS_NUM_SRC-1:0]                irq_s1_reg;   // Sync stage 1
    logic [`DTS_NUM_SRC-1:0]                irq_s2_reg;   // Sync stage 2
    logic [`DTS_NUM_SRC-1:0]                irq_d_reg;    // Edge detect
    logic                                   stby_s1_reg;
    logic                                   stby_s2_reg;
    logic [`DTS_NUM_SRC-1:0]                irq_rise;

    // Interrupts come from other logic possibly on other clocks; synchronise
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            irq_s1_reg  <= '0;
            irq_s2_reg  <= '0;
            irq_d_reg   <= '0;
            stby_s1_reg <= 1'b0;
            stby_s2_reg <= 1'b0;
        end else if (CE) begin
            irq_s1_reg  <= IRQ_IN;
            irq_s2_reg  <= irq_s1_reg;
            irq_d_reg   <= irq_s2_reg;
            stby_s1_reg <= STANDBY;
            stby_s2_reg <= stby_s1_reg;
        end
    end

    // One event per rising edge; standby masks all of them
    assign irq_rise = (irq_s2_reg & ~irq_d_reg) & {`DTS_NUM_SRC{~stby_s2_reg}};

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    // Priority: interrupt set beats transfer-start clear and software write of 0
    always_comb begin
        sel_next   = sel_reg;
        flag_next  = flag_reg;
        start_next = '0;
        rd_next    = rd_reg;
        for (int ch = 0; ch < `DTS_NUM_CH; ch++) begin
            // Software write; selector only expected while disabled
            if (REG_WR[ch].byte_we) begin
                sel_next[ch]  = REG_WR[ch].wdata[`DTS_SEL_MSB:`DTS_SEL_LSB];
                flag_next[ch] = REG_WR[ch].wdata[`DTS_FLAG_BIT];
            end else if (REG_WR[ch].bit_we) begin
                flag_next[ch] = REG_WR[ch].wdata[`DTS_FLAG_BIT];
            end
            // Start consumes the pending request
            if (CHANNEL_ENABLE[ch] && flag_reg[ch] && !start_reg[ch]) begin
                start_next[ch] = 1'b1;
                flag_next[ch]  = 1'b0;
            end
            // Interrupt sets flag even when disabled; set wins
            if (src_hit(sel_reg[ch], irq_rise)) begin
                flag_next[ch] = 1'b1;
            end
            // Bit 6 reads zero
            rd_next[ch] = {flag_next[ch], 1'b0, sel_next[ch]};
        end
    end

    // Registers only
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sel_reg   <= '0;
            flag_reg  <= '0;
            start_reg <= '0;
            rd_reg    <= '0;
        end else if (CE) begin
            sel_reg   <= sel_next;
            flag_reg  <= flag_next;
            start_reg <= start_next;
            rd_reg    <= rd_next;
        end
    end

    // Outputs straight from flip-flops
    assign TRIGGER_FACTOR_REG = rd_reg;
    assign TRANSFER_START     = start_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Quiet cycle: no software write on that channel
    logic [`DTS_NUM_CH-1:0] no_wr;
    always_comb begin
        for (int ch = 0; ch < `DTS_NUM_CH; ch++) begin
            no_wr[ch] = !REG_WR[ch].byte_we && !REG_WR[ch].bit_we;
        end
    end

    // Selected interrupt must raise the flag next cycle
    property p_flag_set;
        @(posedge MCLK) disable iff (RST)
        CE && src_hit(sel_reg[0], irq_rise) |=> flag_reg[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set by source");

    // Enabled channel with a pending flag and no start in flight
    sequence s_pending;
        CE && CHANNEL_ENABLE[0] && flag_reg[0] && !start_reg[0];
    endsequence
    // Such a channel must start on the next edge
    property p_start;
        @(posedge MCLK) disable iff (RST)
        s_pending |=> TRANSFER_START[0];
    endproperty
    a_start: assert property (p_start) else $error("pending flag did not start");

    // Standby keeps a clear flag clear, whatever fires
    property p_standby;
        @(posedge MCLK) disable iff (RST)
        CE && stby_s2_reg && !flag_reg[0] && no_wr[0] |=> !flag_reg[0];
    endproperty
    a_standby: assert property (p_standby) else $error("interrupt seen in standby");

    // Selector zero never lets the flag rise on its own
    property p_zero_sel;
        @(posedge MCLK) disable iff (RST)
        CE && sel_reg[0] == `DTS_SEL_NONE && !flag_reg[0] && no_wr[0] |=> !flag_reg[0];
    endproperty
    a_zero_sel: assert property (p_zero_sel) else $error("flag set with selector zero");

    // First pin line belongs to code two
    property p_pin0;
        @(posedge MCLK) disable iff (RST)
        CE && sel_reg[0] == `DTS_SEL_PIN0 && irq_rise[1] |=> flag_reg[0];
    endproperty
    a_pin0: assert property (p_pin0) else $error("pin 0 code mapping wrong");

    // Read image always mirrors flag and selector
    property p_readback;
        @(posedge MCLK) disable iff (RST)
        TRIGGER_FACTOR_REG[0] == {flag_reg[0], 1'b0, sel_reg[0]};
    endproperty
    a_readback: assert property (p_readback) else $error("read-back mismatch");

    // Byte write lands in the selector
    property p_byte_wr;
        @(posedge MCLK) disable iff (RST)
        CE && REG_WR[0].byte_we |=> sel_reg[0] == $past(REG_WR[0].wdata[5:0]);
    endproperty
    a_byte_wr: assert property (p_byte_wr) else $error("byte write lost");

    // Start consumes the flag and does not repeat
    property p_clear;
        @(posedge MCLK) disable iff (RST)
        s_pending ##0 (!src_hit(sel_reg[0], irq_rise) && no_wr[0]) |=> !flag_reg[0] ##1 !TRANSFER_START[0];
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared on start");

    // Start pulses never come back to back
    property p_one_start;
        @(posedge MCLK) disable iff (RST)
        CE && TRANSFER_START[0] |=> !TRANSFER_START[0];
    endproperty
    a_one_start: assert property (p_one_start) else $error("start pulse repeated");

    // Low enable freezes everything software can see
    property p_freeze;
        @(posedge MCLK) disable iff (RST)
        !CE |=> $stable(TRIGGER_FACTOR_REG) && $stable(TRANSFER_START);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while enable low");

endmodule

/* File: verif/dts_irq_src.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Peripheral interrupt source model
// ----------------------------------------
module dts_irq_src
    import dts_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Fire strobe and selector code
    input  wire logic        fire,
    input  wire logic [5:0]  code,
    // Interrupt lines, bit k is code k+1
    output logic [33:0]      irq
);
    // Two-cycle pulse so the input synchroniser cannot miss it
    logic [1:0] cnt_reg = 2'h0;
    always_ff @(posedge clk) begin
        if (fire)
            cnt_reg <= 2'h2;
        else if (cnt_reg != 2'h0)
            cnt_reg <= cnt_reg - 2'h1;
    end
    // Lines idle low between pulses; code 0 drives nothing
    always_comb begin
        irq = '0;
        if (cnt_reg != 2'h0 && code != 6'h00 && code <= 6'h22)
            irq[code - 6'h01] = 1'b1;
    end
endmodule

/* File: verif/dts_trigger_select_tb.sv */
`timescale 1ns/100ps
module dts_trigger_select_tb;
    import dts_pkg::*;
    // ----------------------------------------
    // Stimulus and observation
    // ----------------------------------------
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic            stby = 1'b0;
    logic            fire = 1'b0;
    logic            ce = 1'b1;
    logic [5:0]      code = 6'h00;
    logic [33:0]     irq;
    dts_wr_t [3:0]   wr = '0;
    logic [3:0]      en = 4'h0;
    logic [3:0][7:0] img;
    logic [3:0]      start;
    logic [7:0]      lfsr = 8'h40;
    int              fail_count = 0;
    int              cmp_count = 0;
    always #12.5 clk = ~clk;
    dts_irq_src src (.clk(clk), .fire(fire), .code(code), .irq(irq));
    dts_trigger_select dut (.MCLK(clk), .RST(rst), .CE(ce), .IRQ_IN(irq), .STANDBY(stby),
        .REG_WR(wr), .CHANNEL_ENABLE(en), .TRIGGER_FACTOR_REG(img), .TRANSFER_START(start));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // Read image: flag, reserved zero, selector
    function automatic logic [7:0] exp_img(input logic f, input logic [5:0] s);
        return {f, 1'b0, s};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle register write; bit write touches the flag only
    task automatic wr_reg(input int ch, input logic [7:0] d, input logic bitw);
        wr[ch] <= '{byte_we: ~bitw, bit_we: bitw, wdata: d};
        @(posedge clk);
        wr[ch] <= '0;
        repeat (2) @(posedge clk);
    endtask
    task automatic pulse(input logic [5:0] c);
        code <= c;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        int ch;
        int n;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int c = 0; c < 4; c++)
            chk(img[c], 8'h00);
        // Codes 1 to 34 on a random disabled channel; selector changed with flag 0
        for (int k = 1; k <= 34; k++) begin
            ch = int'(lfsr[1:0]);
            lfsr = nxt(lfsr);
            wr_reg(ch, exp_img(1'b0, 6'(k)), 1'b0);
            pulse(6'(k));
            chk(img[ch], exp_img(1'b1, 6'(k)));
            chk({4'h0, start}, 8'h00);
            wr_reg(ch, exp_img(1'b0, 6'(k)), 1'b0);
        end
        $display("Source map test done");
        wr_reg(0, 8'h00, 1'b0);
        pulse(6'(lfsr % 34 + 1));
        chk(img[0], 8'h00);
        wr_reg(0, 8'h02, 1'b0);
        chk(img[0], exp_img(1'b0, 6'h02));
        stby <= 1'b1;
        repeat (3) @(posedge clk);
        pulse(6'h02);
        chk(img[0], exp_img(1'b0, 6'h02));
        stby <= 1'b0;
        repeat (3) @(posedge clk);
        $display("Masking test done");
        // Pending flag, then enable: one start pulse, flag consumed
        pulse(6'h02);
        chk(img[0], exp_img(1'b1, 6'h02));
        @(posedge clk);
        en[0] <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (start[0] !== 1'b1 && n < 5);
        chk({7'h00, start[0]}, 8'h01);
        @(negedge clk);
        chk({7'h00, start[0]}, 8'h00);
        chk(img[0], exp_img(1'b0, 6'h02));
        $display("Start test done");
        wr_reg(2, 8'h00, 1'b0);
        wr_reg(2, 8'hbf, 1'b1);
        chk(img[2], 8'h80);
        $display("Bit access test done");
        // Enable low: a byte write must not land
        ce <= 1'b0;
        wr_reg(2, 8'h05, 1'b0);
        ce <= 1'b1;
        chk(img[2], 8'h80);
        $display("Freeze test done");
        end_sim();
    end
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        end_sim();
    end
endmodule
